// ---- verilog/sbeah_pkg.sv ----
// package: offsets, field layout and encodings of the high address capture
`default_nettype none
package sbeah_pkg;
	// register placement and width
	localparam logic [11:0] SBEAH_OFFSET = 12'h120;
	localparam int SBEAH_WIDTH = 64;
	// field positions
	localparam int ODD_MASK_HI = 63;
	localparam int ODD_MASK_LO = 60;
	localparam int FILL_UP_HI = 59;
	localparam int FILL_UP_LO = 56;
	localparam int CMDR_HI_HI = 55;
	localparam int CMDR_HI_LO = 53;
	localparam int TTYPE_HI_HI = 52;
	localparam int TTYPE_HI_LO = 50;
	localparam int XADDR_HI_HI = 49;
	localparam int XADDR_HI_LO = 34;
	localparam int FILL_MID_HI = 33;
	localparam int FILL_MID_LO = 32;
	localparam int EVEN_MASK_HI = 31;
	localparam int EVEN_MASK_LO = 28;
	localparam int FILL_LOW_HI = 27;
	localparam int FILL_LOW_LO = 24;
	localparam int CMDR_LO_HI = 23;
	localparam int CMDR_LO_LO = 21;
	localparam int TTYPE_LO_HI = 20;
	localparam int TTYPE_LO_LO = 18;
	localparam int XADDR_LO_HI = 17;
	localparam int XADDR_LO_LO = 2;
	localparam int FILL_BOT_HI = 1;
	localparam int FILL_BOT_LO = 0;
	// bits that always read as ones
	localparam logic [63:0] SBEAH_ONES = 64'h0f00_0003_0f00_0003;
	// error log bit that clears the parity flag when written with one
	localparam int CA_PAR_ERR_BIT = 2;
	// commander identifier codes
	localparam logic [2:0] CMDR_CPU3 = 3'h0;
	localparam logic [2:0] CMDR_CPU0 = 3'h1;
	localparam logic [2:0] CMDR_CPU1 = 3'h2;
	localparam logic [2:0] CMDR_CPU2 = 3'h3;
	localparam logic [2:0] CMDR_IO_STD = 3'h4;
	localparam logic [2:0] CMDR_IO_EXP = 3'h5;
	// transaction type codes
	localparam logic [2:0] TT_READ = 3'h0;
	localparam logic [2:0] TT_EXCHANGE = 3'h2;
	localparam logic [2:0] TT_WRITE = 3'h4;
	localparam logic [2:0] TT_NULL = 3'h7;
	// capture controller states
	typedef enum logic [1:0] {
		SBEAH_TRACK = 2'b01,
		SBEAH_FROZEN = 2'b10
	} sbeah_state_e;
endpackage
`default_nettype wire

// ---- verilog/sbeah_capture.sv ----
// high address capture register for the system bus error log
`timescale 1ns/1ps
`default_nettype none
module sbeah_capture
	import sbeah_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [63:0] BUS_CA_HIGH,
	input wire logic CA_CYCLE,
	input wire logic OWN_COMMANDER,
	input wire logic CA_NOACK,
	input wire logic CA_PAR_ERR_EVT,
	input wire logic ERR_LOGGED,
	input wire logic ERR_FLAGS_CLEAR,
	input wire logic CSR_SEL,
	input wire logic CSR_WR,
	input wire logic [11:0] CSR_ADDR,
	input wire logic [63:0] CSR_WDATA,
	output logic [63:0] CSR_RDATA,
	output logic CA_PAR_ERR,
	output logic FROZEN
);
	// ----------------------------------------
	// capture and freeze control
	// ----------------------------------------
	sbeah_state_e state_r, state_nxt;
	logic [63:0] cap_r, cap_nxt;
	logic par_r, par_nxt;
	logic [63:0] rdata_r, rdata_nxt;
	logic frozen_r, frozen_nxt;
	logic hit;
	logic take;

	// address decode shared by the read path and the write-one-clear
	function automatic logic csr_hit(input logic sel,
		input logic [11:0] addr);
		return sel && (addr == SBEAH_OFFSET);
	endfunction

	// register select for this capture
	assign hit = csr_hit(CSR_SEL, CSR_ADDR);
	// a cycle is taken when tracking and either ours or erroneous
	assign take = (state_r == SBEAH_TRACK) && CA_CYCLE &&
		(OWN_COMMANDER || CA_NOACK || CA_PAR_ERR_EVT);

	// next state, capture data and parity flag
	always_comb begin
		state_nxt = state_r;
		cap_nxt = cap_r;
		par_nxt = par_r;
		case (state_r)
		SBEAH_TRACK: begin
			if (ERR_LOGGED) begin
				state_nxt = SBEAH_FROZEN;
			end
		end
		SBEAH_FROZEN: begin
			if (ERR_FLAGS_CLEAR && !ERR_LOGGED && !par_r) begin
				state_nxt = SBEAH_TRACK;
			end
		end
		default: state_nxt = SBEAH_TRACK;
		endcase
		if (take) begin
			// bus lines copied as driven except filler bits forced to ones; masks, ids, types and tags
			// sit at their bus positions
			cap_nxt = BUS_CA_HIGH | SBEAH_ONES;
		end
		// write one clears, a new error wins over the clear
		if (hit && CSR_WR && CSR_WDATA[CA_PAR_ERR_BIT]) begin
			par_nxt = 1'b0;
		end
		if (CA_CYCLE && CA_PAR_ERR_EVT) begin
			par_nxt = 1'b1;
		end
		if (CA_CYCLE && CA_PAR_ERR_EVT && state_r == SBEAH_TRACK) begin
			state_nxt = SBEAH_FROZEN;
		end
		// registered copy of the state so the output leaves a flop
		frozen_nxt = (state_nxt == SBEAH_FROZEN);
		// read data; writes to the capture are ignored
		rdata_nxt = hit ? cap_r : 64'h0;
	end

	// registers; capture content starts from a fixed pattern
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= SBEAH_TRACK;
			cap_r <= SBEAH_ONES;
			par_r <= 1'b0;
			frozen_r <= 1'b0;
			rdata_r <= 64'h0;
		end else begin
			state_r <= state_nxt;
			cap_r <= cap_nxt;
			par_r <= par_nxt;
			frozen_r <= frozen_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign CSR_RDATA = rdata_r;
	assign CA_PAR_ERR = par_r;
	assign FROZEN = frozen_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	// own commander cycle seen while tracking
	sequence own_cycle_s;
		CA_CYCLE && OWN_COMMANDER && !FROZEN;
	endsequence
	// erroneous cycle seen while tracking
	sequence err_cycle_s;
		CA_CYCLE && (CA_NOACK || CA_PAR_ERR_EVT) && !FROZEN;
	endsequence
	// error log reports an entry while tracking
	sequence log_seen_s;
		!FROZEN && ERR_LOGGED;
	endsequence
	// every logged flag gone while frozen
	sequence release_s;
		FROZEN && ERR_FLAGS_CLEAR && !ERR_LOGGED && !CA_PAR_ERR;
	endsequence
	// software clears the flag with no new parity error
	sequence par_clear_s;
		hit && CSR_WR && CSR_WDATA[CA_PAR_ERR_BIT] &&
		!(CA_CYCLE && CA_PAR_ERR_EVT);
	endsequence
	// register read of the capture
	sequence cap_read_s;
		hit && !CSR_WR;
	endsequence

	capture_load_a: assert property (take |=> cap_r ==
		($past(BUS_CA_HIGH) | SBEAH_ONES))
		else $error("capture did not load bus lines");
	own_load_a: assert property (own_cycle_s |=> cap_r ==
		($past(BUS_CA_HIGH) | SBEAH_ONES))
		else $error("own cycle not captured");
	err_load_a: assert property (err_cycle_s |=> cap_r ==
		($past(BUS_CA_HIGH) | SBEAH_ONES))
		else $error("error cycle not captured");
	freeze_hold_a: assert property (FROZEN |=>
		$stable(cap_r))
		else $error("capture changed while frozen");
	freeze_enter_a: assert property (log_seen_s |=> FROZEN)
		else $error("freeze not entered on logged error");
	par_freeze_a: assert property (CA_CYCLE &&
		CA_PAR_ERR_EVT && !FROZEN |=> FROZEN)
		else $error("freeze not entered on parity error");
	freeze_leave_a: assert property (release_s |=> !FROZEN)
		else $error("freeze not released");
	freeze_stay_a: assert property (FROZEN &&
		!ERR_FLAGS_CLEAR |=> FROZEN)
		else $error("freeze left without clear");
	noack_low_a: assert property (take && CA_NOACK |=>
		cap_r[31:0] == ($past(BUS_CA_HIGH[31:0]) | SBEAH_ONES[31:0]))
		else $error("failing address not kept");
	odd_mask_a: assert property (take |=> cap_r[63:60] ==
		$past(BUS_CA_HIGH[63:60]))
		else $error("odd masks wrong");
	even_mask_a: assert property (take |=> cap_r[31:28] ==
		$past(BUS_CA_HIGH[31:28]))
		else $error("even masks wrong");
	read_mask_a: assert property (take &&
		BUS_CA_HIGH[TTYPE_HI_HI:TTYPE_HI_LO] == TT_READ |=>
		cap_r[63:60] == $past(BUS_CA_HIGH[63:60]) &&
		cap_r[31:28] == $past(BUS_CA_HIGH[31:28]))
		else $error("read mask lines not kept");
	cmdr_id_a: assert property (take |=>
		cap_r[CMDR_HI_HI:CMDR_HI_LO] ==
		$past(BUS_CA_HIGH[CMDR_HI_HI:CMDR_HI_LO]) &&
		cap_r[CMDR_LO_HI:CMDR_LO_LO] ==
		$past(BUS_CA_HIGH[CMDR_LO_HI:CMDR_LO_LO]))
		else $error("commander id wrong");
	ttype_a: assert property (take |=>
		cap_r[TTYPE_HI_HI:TTYPE_HI_LO] ==
		$past(BUS_CA_HIGH[TTYPE_HI_HI:TTYPE_HI_LO]) &&
		cap_r[TTYPE_LO_HI:TTYPE_LO_LO] ==
		$past(BUS_CA_HIGH[TTYPE_LO_HI:TTYPE_LO_LO]))
		else $error("transaction type wrong");
	xaddr_a: assert property (take |=>
		cap_r[XADDR_HI_HI:XADDR_HI_LO] ==
		$past(BUS_CA_HIGH[XADDR_HI_HI:XADDR_HI_LO]) &&
		cap_r[XADDR_LO_HI:XADDR_LO_LO] ==
		$past(BUS_CA_HIGH[XADDR_LO_HI:XADDR_LO_LO]))
		else $error("victim tag wrong");
	ones_fill_a: assert property (
		cap_r[59:56] == 4'hf && cap_r[27:24] == 4'hf)
		else $error("upper filler bits not ones");
	ones_low_a: assert property (
		cap_r[33:32] == 2'h3 && cap_r[1:0] == 2'h3)
		else $error("lower filler bits not ones");
	read_ones_a: assert property (cap_read_s |=>
		(CSR_RDATA & SBEAH_ONES) == SBEAH_ONES)
		else $error("read filler bits not ones");
	par_set_a: assert property (CA_CYCLE &&
		CA_PAR_ERR_EVT |=> CA_PAR_ERR)
		else $error("parity flag not set");
	par_clear_a: assert property (par_clear_s |=>
		!CA_PAR_ERR)
		else $error("parity flag not cleared");
	par_hold_a: assert property (CA_PAR_ERR &&
		!(hit && CSR_WR && CSR_WDATA[CA_PAR_ERR_BIT]) |=> CA_PAR_ERR)
		else $error("parity flag lost");
	write_ignored_a: assert property (hit && CSR_WR &&
		!take |=> $stable(cap_r))
		else $error("write altered capture");
	read_data_a: assert property (cap_read_s |=>
		CSR_RDATA == $past(cap_r))
		else $error("read data not the capture");
	idle_read_a: assert property (!hit |=>
		CSR_RDATA == 64'h0)
		else $error("read data not zero when unselected");
endmodule
`default_nettype wire

// ---- dv/sbeah_bus_model.sv ----
// far-side commander: one command/address cycle per go
`timescale 1ns/1ps
`default_nettype none
module sbeah_bus_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [66:0] req,
	output logic [63:0] ca_lines,
	output logic cyc,
	output logic [2:0] kind
);
	logic [63:0] idle_r = 64'h0;
	// idle lines flip every cycle so stale data never matches
	always @(posedge clk) idle_r <= ~ca_lines;
	assign cyc = go;
	assign kind = go ? req[66:64] : 3'h0;
	assign ca_lines = go ? req[63:0] : idle_r;
endmodule
`default_nettype wire

// ---- dv/sbeah_capture_tb.sv ----
// self-checking bench for the high address capture register
`timescale 1ns/1ps
`default_nettype none
module sbeah_capture_tb;
	import sbeah_pkg::*;
	logic REF_CLK = 0, RSTN = 0, go = 0, ERR_LOGGED = 0, ERR_FLAGS_CLEAR = 0;
	logic CSR_SEL = 0, CSR_WR = 0, hit = 0, CA_CYCLE, CA_PAR_ERR, FROZEN;
	logic [11:0] CSR_ADDR = 12'h0;
	logic [63:0] CSR_WDATA = 64'h0, BUS_CA_HIGH, CSR_RDATA, cap;
	logic [66:0] req = 67'h0;
	logic [2:0] kind;
	logic [2:0] tts[4] = '{TT_READ, TT_EXCHANGE, TT_WRITE, TT_NULL};
	logic [63:0] expq[$];
	logic [31:0] seed = 32'h22f8;
	int err_total = 0, compares = 0;
	sbeah_bus_model sbeah_bus_model_i (.clk(REF_CLK), .go(go), .req(req),
		.ca_lines(BUS_CA_HIGH), .cyc(CA_CYCLE), .kind(kind));
	sbeah_capture sbeah_capture_i (.REF_CLK(REF_CLK), .RSTN(RSTN),
		.BUS_CA_HIGH(BUS_CA_HIGH), .CA_CYCLE(CA_CYCLE),
		.OWN_COMMANDER(kind[2]),
		.CA_NOACK(kind[1]), .CA_PAR_ERR_EVT(kind[0]), .ERR_LOGGED(ERR_LOGGED),
		.ERR_FLAGS_CLEAR(ERR_FLAGS_CLEAR), .CSR_SEL(CSR_SEL), .CSR_WR(CSR_WR),
		.CSR_ADDR(CSR_ADDR), .CSR_WDATA(CSR_WDATA), .CSR_RDATA(CSR_RDATA),
		.CA_PAR_ERR(CA_PAR_ERR), .FROZEN(FROZEN));
	initial forever #10 REF_CLK = ~REF_CLK;
	// xorshift source
	function automatic logic [63:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return {seed, ~seed ^ 32'h5a3c_96e1};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] want);
		compares++;
		if (got !== want) begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic cy(input logic [2:0] k, input logic [63:0] d);
		@(negedge REF_CLK) req <= {k, d};
		go <= 1'b1;
		@(negedge REF_CLK) go <= 1'b0;
	endtask
	task automatic csr(input logic w, input logic [11:0] a,
		input logic [63:0] d);
		@(negedge REF_CLK) CSR_SEL <= 1'b1;
		CSR_WR <= w;
		CSR_ADDR <= a;
		CSR_WDATA <= d;
		if (!w) expq.push_back(d);
		@(negedge REF_CLK) CSR_SEL <= 1'b0;
	endtask
	// read data appears one cycle after the strobe
	always @(posedge REF_CLK) hit <= CSR_SEL && !CSR_WR;
	always @(negedge REF_CLK) if (hit) chk(CSR_RDATA, expq.pop_front());
	task automatic close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog well past the roughly 70 cycles of the tests
	initial begin
		#100us err_total++;
		close_out();
	end
	initial begin
		repeat (5) @(negedge REF_CLK);
		RSTN = 1'b1;
		for (int i = 0; i < 8; i++) begin
			cap = rnd();
			cap[55:53] = i[2:0];
			cap[23:21] = i[2:0];
			cap[52:50] = tts[i%4];
			cap[20:18] = tts[i%4];
			cy(3'h4, cap);
			csr(0, SBEAH_OFFSET, cap | SBEAH_ONES);
		end
		$display("codes test done");
		csr(1, SBEAH_OFFSET, rnd());
		cy(3'h0, rnd());
		csr(0, SBEAH_OFFSET, cap | SBEAH_ONES);
		csr(0, 12'h128, 64'h0);
		cap = rnd();
		cy(3'h2, cap);
		ERR_LOGGED = 1'b1;
		cy(3'h4, rnd());
		csr(0, SBEAH_OFFSET, cap | SBEAH_ONES);
		chk(64'(FROZEN), 64'h1);
		ERR_LOGGED = 1'b0;
		ERR_FLAGS_CLEAR = 1'b1;
		@(negedge REF_CLK) ERR_FLAGS_CLEAR = 1'b0;
		cap = rnd();
		cy(3'h1, cap);
		cy(3'h4, rnd());
		csr(0, SBEAH_OFFSET, cap | SBEAH_ONES);
		chk(64'(CA_PAR_ERR), 64'h1);
		csr(1, SBEAH_OFFSET, 64'h4);
		chk(64'(CA_PAR_ERR), 64'h0);
		ERR_FLAGS_CLEAR = 1'b1;
		@(negedge REF_CLK) ERR_FLAGS_CLEAR = 1'b0;
		cap = rnd();
		cy(3'h4, cap);
		csr(0, SBEAH_OFFSET, cap | SBEAH_ONES);
		$display("freeze test done");
		repeat (3) @(negedge REF_CLK);
		close_out();
	end
endmodule
`default_nettype wire
